// File: adse_pkg.sv
// Shared constants for the converter sampling-extension and interrupt block.
// Assumes a single 250 MHz clock and word-aligned AHB-Lite register access.
package adse_pkg;
    localparam int NUM_MOD = 19;
    localparam int NUM_IRQ = 4;
    localparam int NUM_EXT = 3;
    localparam int EXT_W   = 8;
    localparam int CNT_W   = 9;

    // Register byte offsets within the block.
    localparam logic [7:0] OFF_CTL16   = 8'hc0;
    localparam logic [7:0] OFF_CTL17   = 8'hc4;
    localparam logic [7:0] OFF_CTL18   = 8'hc8;
    localparam logic [7:0] OFF_IRQ0    = 8'hd0;
    localparam logic [7:0] OFF_IRQ1    = 8'hd4;
    localparam logic [7:0] OFF_IRQ2    = 8'hd8;
    localparam logic [7:0] OFF_IRQ3    = 8'hdc;
    localparam logic [7:0] OFF_FLAGPOS = 8'hf0;
    localparam logic [7:0] OFF_STATUS  = 8'hf4;
    localparam logic [7:0] OFF_MASK    = 8'hf8;

    // Field positions.
    localparam int EXT_LSB = 24;
    localparam int EXT_MSB = 31;
    localparam int SRC_MSB = 18;

    // Reset values.
    localparam logic [7:0]  EXT_RST    = 8'h00;
    localparam logic [18:0] SRC_RST    = 19'h00000;
    localparam logic [3:0]  POS_RST    = 4'h0;
    localparam logic [3:0]  STATUS_RST = 4'h0;
    localparam logic [3:0]  MASK_RST   = 4'h0;

    // Base sampling phase length in converter clocks, before extension.
    localparam int SMP_BASE = 1;

    typedef enum logic [1:0]
    {
        ADSE_IDLE   = 2'b01,
        ADSE_SAMPLE = 2'b10
    } adse_smp_e;
endpackage

// File: adse_evt_if.sv
// Carries conversion events and interrupt enables to the interrupt gate.
// Assumes all signals are on the block clock; clk and rstn come from the top.
`timescale 1ns/1ps
interface adse_evt_if
(
    input wire logic clk,
    input wire logic rstn
);
    logic [adse_pkg::NUM_MOD-1:0]                             soc;
    logic [adse_pkg::NUM_MOD-1:0]                             eoc;
    logic [adse_pkg::NUM_IRQ-1:0][adse_pkg::NUM_MOD-1:0]      en;
    logic [adse_pkg::NUM_IRQ-1:0]                             pos;
    logic [adse_pkg::NUM_IRQ-1:0]                             hit;

    modport ctrl (input clk, input rstn, output soc, output eoc,
                  output en, output pos, input hit);
    modport gate (input clk, input rstn, input soc, input eoc,
                  input en, input pos, output hit);
endinterface

// File: adse_smp_ext.sv
// Sampling phase timer for one sample module with a software extension.
// Assumes trig_i is a one-cycle pulse on the same clock; BASE is at least 1.
`timescale 1ns/1ps
module adse_smp_ext
#(
    parameter int BASE = adse_pkg::SMP_BASE
)
(
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    input  wire logic                       trig_i,
    input  wire logic [adse_pkg::EXT_W-1:0] ext_i,
    output logic                            hold_o
);
    localparam logic [adse_pkg::CNT_W-1:0] BASE_W = adse_pkg::CNT_W'(BASE);

    adse_pkg::adse_smp_e              state;
    logic [adse_pkg::CNT_W-1:0]       cnt;
    logic [adse_pkg::CNT_W-1:0]       next_total;
    logic [adse_pkg::CNT_W-1:0]       total_q;
    logic [adse_pkg::CNT_W-1:0]       run;

    assign next_total = BASE_W + {1'h0, ext_i};

    // The extension is captured at the trigger, so a rewrite during the
    // phase cannot stretch or cut a sample already in progress.
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            state  <= adse_pkg::ADSE_IDLE;
            cnt    <= '0;
            hold_o <= 1'h0;
        end
        else
        begin
            case (state)
                adse_pkg::ADSE_IDLE:
                begin
                    if (trig_i)
                    begin
                        state  <= adse_pkg::ADSE_SAMPLE;
                        cnt    <= next_total - 9'h001;
                        hold_o <= 1'h1;
                    end
                end
                adse_pkg::ADSE_SAMPLE:
                begin
                    if (cnt == 9'h000)
                    begin
                        state  <= adse_pkg::ADSE_IDLE;
                        hold_o <= 1'h0;
                    end
                    else
                    begin
                        cnt <= cnt - 9'h001;
                    end
                end
                default:
                begin
                    state  <= adse_pkg::ADSE_IDLE;
                    hold_o <= 1'h0;
                end
            endcase
        end
    end

    // Helper logic for the checks below.
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            total_q <= '0;
            run     <= '0;
        end
        else
        begin
            if (trig_i && state == adse_pkg::ADSE_IDLE)
                total_q <= next_total;
            run <= hold_o ? run + 9'h001 : 9'h000;
        end
    end

    chk_trig_starts_phase: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (trig_i && state == adse_pkg::ADSE_IDLE) |=> hold_o)
    else $error("sampling phase did not start on trigger");

    chk_phase_exact_len: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $fell(hold_o) |-> run == total_q)
    else $error("sampling phase length differs from base plus extension");
endmodule

// File: adse_irq_gate.sv
// Combines enabled sample module events into the four interrupt events.
// Assumes start and end of conversion inputs are one-cycle pulses.
`timescale 1ns/1ps
module adse_irq_gate
(
    adse_evt_if.gate ev
);
    genvar g;
    for (g = 0; g < adse_pkg::NUM_IRQ; g++)
    begin : g_irq
        logic [adse_pkg::NUM_MOD-1:0] sel;

        assign sel = ev.pos[g] ? ev.soc : ev.eoc;

        always_ff @(posedge ev.clk)
        begin
            if (!ev.rstn)
                ev.hit[g] <= 1'h0;
            else
                ev.hit[g] <= |(sel & ev.en[g]);
        end

        chk_blocked_no_hit: assert property (
            @(posedge ev.clk) disable iff (!ev.rstn)
            ((ev.en[g] == '0) ##1 (ev.en[g] == '0)) |-> !ev.hit[g])
        else $error("interrupt event raised with all sources disabled");

        chk_soc_position: assert property (
            @(posedge ev.clk) disable iff (!ev.rstn)
            (ev.pos[g] && |(ev.soc & ev.en[g])) |=> ev.hit[g])
        else $error("start of conversion event missed in start position");

        chk_eoc_position: assert property (
            @(posedge ev.clk) disable iff (!ev.rstn)
            (!ev.pos[g] && (ev.eoc & ev.en[g]) == '0) |=> !ev.hit[g])
        else $error("event raised in end position without enabled end");
    end
endmodule

// File: adse_top.sv
// Sampling extension for sample modules 16 to 18 and interrupt source
// enables, reached over an AHB-Lite slave with one wait state.
// Assumes conversion events and triggers are same-clock one-cycle pulses.
//
// Summary of operation
// - Modules 16-18 lengthen sampling after trigger.
// - Extension adds exactly 0 to 255 clocks.
// - Four interrupt outputs with consecutive enable registers.
// - Enable bit n belongs to sample module n.
// - Clear bit blocks module event, set passes.
// - Per-interrupt setting picks start or end event.
`timescale 1ns/1ps
module adse_top
#(
    parameter int SMP_BASE = adse_pkg::SMP_BASE
)
(
    input  wire logic                           CLK_I,
    input  wire logic                           RSTN_I,
    input  wire logic                           HSEL_I,
    input  wire logic [31:0]                    HADDR_I,
    input  wire logic [1:0]                     HTRANS_I,
    input  wire logic                           HWRITE_I,
    input  wire logic [2:0]                     HSIZE_I,
    input  wire logic [31:0]                    HWDATA_I,
    input  wire logic                           HREADY_I,
    output logic [31:0]                         HRDATA_O,
    output logic                                HREADYOUT_O,
    output logic                                HRESP_O,
    input  wire logic [adse_pkg::NUM_MOD-1:0]   SOC_I,
    input  wire logic [adse_pkg::NUM_MOD-1:0]   EOC_I,
    input  wire logic [adse_pkg::NUM_EXT-1:0]   TRIG_I,
    output logic [adse_pkg::NUM_EXT-1:0]        SAMPLE_O,
    output logic [adse_pkg::NUM_IRQ-1:0]        CONV_IRQ_FLAG_O,
    output logic                                IRQ_O
);
    localparam int NI = adse_pkg::NUM_IRQ;
    localparam int NM = adse_pkg::NUM_MOD;
    localparam int NE = adse_pkg::NUM_EXT;
    localparam int EW = adse_pkg::EXT_W;

    logic [NE-1:0][EW-1:0]  ext;
    logic [NI-1:0][NM-1:0]  src_en;
    logic [NI-1:0]          pos;
    logic [NI-1:0]          status;
    logic [NI-1:0]          mask;
    logic [NI-1:0]          hit;
    logic [NI-1:0]          w1c;
    logic [NI-1:0]          next_status;
    logic                   take;
    logic                   pend;
    logic                   pwr;
    logic [7:0]             paddr;
    logic [31:0]            rd_word;
    logic                   wr;

    adse_evt_if evt
    (
        .clk  (CLK_I),
        .rstn (RSTN_I)
    );

    assign evt.soc = SOC_I;
    assign evt.eoc = EOC_I;
    assign evt.en  = src_en;
    assign evt.pos = pos;
    assign hit     = evt.hit;

    adse_irq_gate u_gate
    (
        .ev (evt.gate)
    );

    genvar e;
    for (e = 0; e < NE; e++)
    begin : g_ext
        adse_smp_ext #(.BASE(SMP_BASE)) u_smp
        (
            .clk_i  (CLK_I),
            .rstn_i (RSTN_I),
            .trig_i (TRIG_I[e]),
            .ext_i  (ext[e]),
            .hold_o (SAMPLE_O[e])
        );
    end

    // Only the low address byte is decoded; selection comes from HSEL.
    // The data phase always takes one wait state so that a read that
    // follows a write back to back sees the freshly written value.
    assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign wr   = pend && pwr;

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            pend        <= 1'h0;
            pwr         <= 1'h0;
            paddr       <= 8'h00;
            HREADYOUT_O <= 1'h1;
        end
        else if (pend)
        begin
            pend        <= 1'h0;
            HREADYOUT_O <= 1'h1;
        end
        else if (take)
        begin
            pend        <= 1'h1;
            pwr         <= HWRITE_I;
            paddr       <= HADDR_I[7:0];
            HREADYOUT_O <= 1'h0;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
            HRESP_O <= 1'h0;
        else
            HRESP_O <= 1'h0;
    end

    always_comb
    begin
        rd_word = 32'h00000000;
        case (paddr)
            adse_pkg::OFF_CTL16:   rd_word = {ext[0], 24'h000000};
            adse_pkg::OFF_CTL17:   rd_word = {ext[1], 24'h000000};
            adse_pkg::OFF_CTL18:   rd_word = {ext[2], 24'h000000};
            adse_pkg::OFF_IRQ0:    rd_word = {13'h0000, src_en[0]};
            adse_pkg::OFF_IRQ1:    rd_word = {13'h0000, src_en[1]};
            adse_pkg::OFF_IRQ2:    rd_word = {13'h0000, src_en[2]};
            adse_pkg::OFF_IRQ3:    rd_word = {13'h0000, src_en[3]};
            adse_pkg::OFF_FLAGPOS: rd_word = {28'h0000000, pos};
            adse_pkg::OFF_STATUS:  rd_word = {28'h0000000, status};
            adse_pkg::OFF_MASK:    rd_word = {28'h0000000, mask};
            default:               rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
            HRDATA_O <= 32'h00000000;
        else if (pend && !pwr)
            HRDATA_O <= rd_word;
    end

    // Extension fields of modules 16 to 18.
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            ext <= {NE{adse_pkg::EXT_RST}};
        end
        else if (wr)
        begin
            case (paddr)
                adse_pkg::OFF_CTL16:
                    ext[0] <= HWDATA_I[adse_pkg::EXT_MSB:adse_pkg::EXT_LSB];
                adse_pkg::OFF_CTL17:
                    ext[1] <= HWDATA_I[adse_pkg::EXT_MSB:adse_pkg::EXT_LSB];
                adse_pkg::OFF_CTL18:
                    ext[2] <= HWDATA_I[adse_pkg::EXT_MSB:adse_pkg::EXT_LSB];
                default:
                    ext <= ext;
            endcase
        end
    end

    // Source enables, one register per interrupt at consecutive words.
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            src_en <= {NI{adse_pkg::SRC_RST}};
        end
        else if (wr)
        begin
            case (paddr)
                adse_pkg::OFF_IRQ0:
                    src_en[0] <= HWDATA_I[adse_pkg::SRC_MSB:0];
                adse_pkg::OFF_IRQ1:
                    src_en[1] <= HWDATA_I[adse_pkg::SRC_MSB:0];
                adse_pkg::OFF_IRQ2:
                    src_en[2] <= HWDATA_I[adse_pkg::SRC_MSB:0];
                adse_pkg::OFF_IRQ3:
                    src_en[3] <= HWDATA_I[adse_pkg::SRC_MSB:0];
                default:
                    src_en <= src_en;
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
            pos <= adse_pkg::POS_RST;
        else if (wr && paddr == adse_pkg::OFF_FLAGPOS)
            pos <= HWDATA_I[NI-1:0];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
            mask <= adse_pkg::MASK_RST;
        else if (wr && paddr == adse_pkg::OFF_MASK)
            mask <= HWDATA_I[NI-1:0];
    end

    // A new event in the same cycle as a clear keeps its flag set.
    assign w1c = (wr && paddr == adse_pkg::OFF_STATUS) ? HWDATA_I[NI-1:0]
                                                       : 4'h0;
    assign next_status = (status & ~w1c) | hit;

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
            status <= adse_pkg::STATUS_RST;
        else
            status <= next_status;
    end

    // Both outputs lag the status by one clock to come from flip-flops.
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            CONV_IRQ_FLAG_O <= 4'h0;
            IRQ_O           <= 1'h0;
        end
        else
        begin
            CONV_IRQ_FLAG_O <= status;
            IRQ_O           <= |(status & mask);
        end
    end

    sequence s_addr;
        HSEL_I && HTRANS_I[1] && HREADY_I && !pend;
    endsequence

    sequence s_one_wait;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence

    chk_bus_one_wait: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_addr |=> s_one_wait)
    else $error("bus data phase did not complete after one wait state");

    chk_resp_okay: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        !HRESP_O)
    else $error("bus response not OKAY");

    chk_src_write: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (wr && paddr == adse_pkg::OFF_IRQ2)
            |=> src_en[2] == $past(HWDATA_I[18:0]))
    else $error("interrupt 2 source enable not written");

    chk_ext_write: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (wr && paddr == adse_pkg::OFF_CTL17)
            |=> ext[1] == $past(HWDATA_I[31:24]))
    else $error("module 17 extension not written");

    chk_set_wins: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (hit[0] && w1c[0]) |=> status[0] ##1 CONV_IRQ_FLAG_O[0])
    else $error("event lost against a same-cycle clear");

    chk_flag_sticky: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (status[1] && !w1c[1]) |=> status[1])
    else $error("status flag dropped without a clear");

    chk_irq_level: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        ##1 IRQ_O == |($past(status) & $past(mask)))
    else $error("interrupt output does not follow masked status");

    chk_enabled_event: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (!pos[3] && EOC_I[18] && src_en[3][18]) |=> ##1 status[3])
    else $error("enabled module 18 end event did not set flag 3");

    // Read data must mirror the register that the address phase named.
    chk_read_src: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (pend && !pwr && paddr == adse_pkg::OFF_IRQ1)
            |=> HRDATA_O == {13'h0000, $past(src_en[1])})
    else $error("interrupt 1 source enable read back wrongly");

    chk_read_ext: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (pend && !pwr && paddr == adse_pkg::OFF_CTL18)
            |=> HRDATA_O == {$past(ext[2]), 24'h000000})
    else $error("module 18 extension read back wrongly");

    chk_flag_clear: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (w1c[2] && !hit[2]) |=> !status[2])
    else $error("status flag 2 not cleared by a written one");
endmodule

// File: adse_top_bench.sv
// Self-checking bench for the sampling extension and interrupt enable block.
// Assumes the design files are compiled first; the bench is the bus master.
`timescale 1ns/1ps
module adse_top_bench;
    localparam int BASE  = 1;
    localparam int LIMIT = 20000;

    logic                          CLK_I;
    logic                          RSTN_I;
    logic                          HSEL_I;
    logic [31:0]                   HADDR_I;
    logic [1:0]                    HTRANS_I;
    logic                          HWRITE_I;
    logic [2:0]                    HSIZE_I;
    logic [31:0]                   HWDATA_I;
    logic [31:0]                   HRDATA_O;
    logic                          HREADYOUT_O;
    logic                          HRESP_O;
    logic [adse_pkg::NUM_MOD-1:0]  SOC_I;
    logic [adse_pkg::NUM_MOD-1:0]  EOC_I;
    logic [adse_pkg::NUM_EXT-1:0]  TRIG_I;
    logic [adse_pkg::NUM_EXT-1:0]  SAMPLE_O;
    logic [adse_pkg::NUM_IRQ-1:0]  CONV_IRQ_FLAG_O;
    logic                          IRQ_O;
    int                            bad_count;
    int                            n_tests;
    int                            cycles;
    logic [31:0]                   rd;

    adse_top #(.SMP_BASE(BASE)) i_dut
    (
        .CLK_I           (CLK_I),
        .RSTN_I          (RSTN_I),
        .HSEL_I          (HSEL_I),
        .HADDR_I         (HADDR_I),
        .HTRANS_I        (HTRANS_I),
        .HWRITE_I        (HWRITE_I),
        .HSIZE_I         (HSIZE_I),
        .HWDATA_I        (HWDATA_I),
        .HREADY_I        (HREADYOUT_O),
        .HRDATA_O        (HRDATA_O),
        .HREADYOUT_O     (HREADYOUT_O),
        .HRESP_O         (HRESP_O),
        .SOC_I           (SOC_I),
        .EOC_I           (EOC_I),
        .TRIG_I          (TRIG_I),
        .SAMPLE_O        (SAMPLE_O),
        .CONV_IRQ_FLAG_O (CONV_IRQ_FLAG_O),
        .IRQ_O           (IRQ_O)
    );

    always #2 CLK_I = ~CLK_I;

    task automatic close_out();
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // A hung handshake is cut short by the cycle ceiling below.
    task automatic wait_ready();
        do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] data);
        HSEL_I   <= 1'b1;
        HTRANS_I <= 2'b10;
        HWRITE_I <= wr;
        HADDR_I  <= {24'h000000, a};
        wait_ready();
        HSEL_I   <= 1'b0;
        HTRANS_I <= 2'b00;
        HWDATA_I <= wd;
        wait_ready();
        data = HRDATA_O;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h00000000, d);
    endtask

    // Events are one-cycle pulses; the flags settle three edges later.
    task automatic pulse(input logic soc, input logic [18:0] v);
        if (soc)
            SOC_I <= v;
        else
            EOC_I <= v;
        @(posedge CLK_I);
        SOC_I <= 19'h00000;
        EOC_I <= 19'h00000;
        repeat (4) @(posedge CLK_I);
    endtask

    task automatic clear_flags();
        wr_reg(adse_pkg::OFF_STATUS, 32'h0000000f);
        repeat (2) @(posedge CLK_I);
    endtask

    // Holds the trigger over the first sampling edge, which must be ignored.
    task automatic sample_run(input int k, input logic [7:0] ext);
        int cnt;
        cnt = 0;
        wr_reg(8'hc0 + 8'(4 * k), {ext, 24'h000000});
        TRIG_I[k] <= 1'b1;
        @(posedge CLK_I);
        do
        begin
            @(posedge CLK_I);
            TRIG_I[k] <= 1'b0;
            if (SAMPLE_O[k] === 1'b1)
                cnt++;
        end
        while (SAMPLE_O[k] === 1'b1 && cnt < 400);
        check(32'(cnt), 32'(BASE) + {24'h000000, ext});
    endtask

    always @(posedge CLK_I)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        CLK_I    = 1'b0;
        RSTN_I   = 1'b0;
        HSEL_I   = 1'b0;
        HADDR_I  = 32'h00000000;
        HTRANS_I = 2'b00;
        HWRITE_I = 1'b0;
        HSIZE_I  = 3'b010;
        HWDATA_I = 32'h00000000;
        SOC_I    = 19'h00000;
        EOC_I    = 19'h00000;
        TRIG_I   = 3'b000;
        bad_count = 0;
        n_tests  = 0;
        cycles   = 0;
        repeat (5) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        @(posedge CLK_I);
        check({29'h0, HREADYOUT_O, IRQ_O, HRESP_O}, 32'h00000004);
        // Reset values, writable fields and reserved bits of the extension and source enable registers.
        for (int i = 0; i < 7; i++)
        begin
            logic [7:0] a;
            a = (i < 3) ? 8'hc0 + 8'(4 * i) : 8'hd0 + 8'(4 * (i - 3));
            rd_reg(a, rd);
            check(rd, 32'h00000000);
            wr_reg(a, 32'hffffffff);
            rd_reg(a, rd);
            check(rd, (i < 3) ? 32'hff000000 : 32'h0007ffff);
            wr_reg(a, 32'h00000000);
        end
        wr_reg(8'hcc, 32'hffffffff);
        rd_reg(8'hcc, rd);
        check(rd, 32'h00000000);
        rd_reg(adse_pkg::OFF_STATUS, rd);
        check(rd, 32'h00000000);
        // Extension lengths, including both ends of the field.
        sample_run(0, 8'h00);
        sample_run(1, 8'h02);
        sample_run(2, 8'hff);
        sample_run(0, 8'h05);
        // Each enable bit passes only its own module to its own interrupt.
        for (int g = 0; g < 4; g++)
        begin
            wr_reg(adse_pkg::OFF_MASK, 32'(1 << g));
            for (int n = 0; n < 19; n++)
            begin
                wr_reg(8'hd0 + 8'(4 * g), 32'(1 << n));
                pulse(1'b0, ~19'(1 << n));
                check({28'h0, CONV_IRQ_FLAG_O}, 32'h0);
                check({31'h0, IRQ_O}, 32'h0);
                pulse(1'b0, 19'(1 << n));
                check({28'h0, CONV_IRQ_FLAG_O}, 32'(1 << g));
                check({31'h0, IRQ_O}, 32'h1);
                clear_flags();
                check({28'h0, CONV_IRQ_FLAG_O}, 32'h0);
            end
            wr_reg(8'hd0 + 8'(4 * g), 32'h00000000);
        end
        // Two enabled sources firing together raise a single flag.
        wr_reg(adse_pkg::OFF_IRQ1, 32'h00000084);
        pulse(1'b0, 19'h00084);
        check({28'h0, CONV_IRQ_FLAG_O}, 32'h2);
        clear_flags();
        // Flag position selects start or end of conversion per interrupt.
        for (int g = 0; g < 4; g++)
            wr_reg(8'hd0 + 8'(4 * g), 32'h00000008);
        wr_reg(adse_pkg::OFF_FLAGPOS, 32'h00000005);
        wr_reg(adse_pkg::OFF_MASK, 32'h00000000);
        pulse(1'b1, 19'h00008);
        check({28'h0, CONV_IRQ_FLAG_O}, 32'h5);
        check({31'h0, IRQ_O}, 32'h0);
        rd_reg(adse_pkg::OFF_STATUS, rd);
        check(rd, 32'h00000005);
        clear_flags();
        pulse(1'b0, 19'h00008);
        check({28'h0, CONV_IRQ_FLAG_O}, 32'ha);
        wr_reg(adse_pkg::OFF_MASK, 32'h0000000f);
        @(posedge CLK_I);
        check({31'h0, IRQ_O}, 32'h1);
        clear_flags();
        check({31'h0, IRQ_O}, 32'h0);
        // An event in the same cycle as its clear keeps the flag set.
        fork
            wr_reg(adse_pkg::OFF_STATUS, 32'h0000000f);
            pulse(1'b1, 19'h00008);
        join
        check({28'h0, CONV_IRQ_FLAG_O}, 32'h5);
        check({31'h0, IRQ_O}, 32'h1);
        clear_flags();
        check({28'h0, CONV_IRQ_FLAG_O}, 32'h0);
        close_out();
    end
endmodule
